// *** src/kse_core.sv ***
// Keypad and touchpoint data entry controller
`default_nettype none
`include "kse_defs.svh"

module kse_core
	import kse_pkg::*;
#(
	parameter int DEPTH = `KSE_SCR_DEPTH,
	parameter int W     = `KSE_CHAR_W
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic             key_valid_i,
	input  wire logic [4:0]       key_code_i,
	input  wire logic             touch_valid_i,
	input  wire logic [2:0]       touch_idx_i,
	input  wire logic [7:0]       entry_mask_i,
	input  wire logic [7:0]       dual_mask_i,
	input  wire logic [3:0]       int_limit_i,
	input  wire logic [3:0]       page_count_i,
	input  wire logic             set_sel_i,
	input  wire logic             set_is_wp_i,
	input  wire logic [3:0]       wp_page_i,
	input  wire logic             verdict_valid_i,
	input  wire kse_verdict_t     verdict_i,
	input  wire logic [3:0]       verdict_msg_i,
	input  wire logic             sysop_err_i,
	input  wire logic [3:0]       sysop_msg_i,
	input  wire logic             warn_i,
	output var  logic [DEPTH*W-1:0] scratch_o,
	output var  logic [3:0]       scratch_len_o,
	output var  logic             dp_implied_o,
	output var  logic             cursor_on_o,
	output var  logic [2:0]       cursor_pos_o,
	output var  logic             cursor_line_o,
	output var  logic             commit_req_o,
	output var  logic             store_o,
	output var  logic [2:0]       store_field_o,
	output var  logic             store_line_o,
	output var  logic             restore_o,
	output var  logic [3:0]       msg_code_o,
	output var  logic             msg_lock_o,
	output var  logic             warn_light_o,
	output var  logic [3:0]       page_o
);
	// ------------------------------------------------------------
	// Pin synchronisers and scratch buffer
	// ------------------------------------------------------------
	logic       key_s;
	logic [4:0] code_s;
	logic       touch_s;
	logic [2:0] tidx_s;

	// Code bits must settle before valid rises; they share the valid's delay
	kse_sync #(.WIDTH(10)) u_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({key_valid_i, key_code_i, touch_valid_i, touch_idx_i}),
		.q_o     ({key_s, code_s, touch_s, tidx_s})
	);

	kse_scrop_t         scr_op;
	logic [W-1:0]       scr_ch;
	logic [DEPTH*W-1:0] scr_buf;
	logic [3:0]         scr_len;

	kse_scratch #(.DEPTH(DEPTH), .W(W)) u_scratch (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.op_i    (scr_op),
		.ch_i    (scr_ch),
		.buf_o   (scr_buf),
		.len_o   (scr_len)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	kse_state_t state_r, state_nxt;
	kse_msgk_t  msgk_r, msgk_nxt;
	logic       key_prev_r, key_prev_nxt, touch_prev_r, touch_prev_nxt;
	logic       post_r, post_nxt, cur_on_r, cur_on_nxt, cur_line_r, cur_line_nxt;
	logic [2:0] cur_pos_r, cur_pos_nxt, sfield_r, sfield_nxt;
	logic [3:0] msg_r, msg_nxt, page_r, page_nxt;
	logic       warn_r, warn_nxt, req_r, req_nxt, store_r, store_nxt;
	logic       sline_r, sline_nxt, rest_r, rest_nxt, lock_r, lock_nxt, dpi_r, dpi_nxt;

	logic       lock, key_take, touch_take, do_wipe, do_adv, moved, dp_found;
	logic [3:0] dp_idx, int_digits, nx;

	// Next entry touchpoint above p: index order is left column then right
	function automatic logic [3:0] next_entry(input logic [2:0] p, input logic [7:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (i > int'(p) && m[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : next_entry

	assign lock       = (msgk_r == KSE_MK_ENTRY) || (msgk_r == KSE_MK_SYSOP);
	assign key_take   = key_s && !key_prev_r && (state_r == KSE_IDLE);
	assign touch_take = touch_s && !touch_prev_r && (state_r == KSE_IDLE) && !key_take;

	always_comb begin
		dp_found = 1'b0;
		dp_idx   = 4'h0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (4'(i) < scr_len && scr_buf[i*W +: W] == `KSE_CH_POINT) begin
				dp_found = 1'b1;
				dp_idx   = 4'(i);
			end
		end
		int_digits = dp_found ? scr_len - dp_idx - 4'h1 : scr_len;
	end

	// ------------------------------------------------------------
	// Event processing
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;      msgk_nxt = msgk_r;      msg_nxt = msg_r;
		key_prev_nxt = key_s ? key_prev_r : 1'b0;
		touch_prev_nxt = touch_s ? touch_prev_r : 1'b0;
		post_nxt = post_r;        cur_on_nxt = cur_on_r;  cur_pos_nxt = cur_pos_r;
		cur_line_nxt = cur_line_r; page_nxt = page_r;     warn_nxt = warn_r;
		sfield_nxt = sfield_r;    sline_nxt = sline_r;
		req_nxt = 1'b0;  store_nxt = 1'b0;  rest_nxt = 1'b0;
		scr_op = KSE_OP_NONE;     scr_ch = `KSE_CH_BLANK;
		do_wipe = 1'b0;  do_adv = 1'b0;  moved = 1'b0;
		nx = next_entry(cur_pos_r, entry_mask_i);
		case (state_r)
			KSE_IDLE: begin
				if (key_take) begin
					key_prev_nxt = 1'b1;
					post_nxt     = 1'b0;
					if (lock) begin
						do_wipe = (code_s == `KSE_KEY_WIPE);
					end else if (code_s <= `KSE_KEY_DIG_MAX) begin
						scr_op   = KSE_OP_PUSH;
						scr_ch   = `KSE_CH_ZERO + {3'h0, code_s};
						post_nxt = (scr_len != 4'(DEPTH));
					end else begin
						case (code_s)
							`KSE_KEY_POST1, `KSE_KEY_POST2, `KSE_KEY_POST3: if (post_r) begin
								scr_op = KSE_OP_REPL;
								scr_ch = `KSE_CH_LETTER + 8'(3 * (scr_buf[3:0]))
									+ {3'h0, code_s} - {3'h0, `KSE_KEY_POST1};
							end
							`KSE_KEY_POINT: scr_op = KSE_OP_PUSH;
							`KSE_KEY_BKSP:  scr_op = KSE_OP_POP;
							`KSE_KEY_WIPE:  do_wipe = 1'b1;
							`KSE_KEY_ACK:   warn_nxt = 1'b0;
							`KSE_KEY_PG_FWD: begin
								page_nxt = (page_r >= page_count_i) ? `KSE_PAGE_FIRST
									: page_r + 4'h1;
								cur_on_nxt = 1'b0;
								moved = 1'b1;
							end
							`KSE_KEY_PG_BACK: begin
								page_nxt = (page_r <= `KSE_PAGE_FIRST) ? page_count_i
									: page_r - 4'h1;
								cur_on_nxt = 1'b0;
								moved = 1'b1;
							end
							`KSE_KEY_COMMIT: if (cur_on_r) begin
								if (scr_len == 4'h0) begin
									do_adv = 1'b1;
								end else if (int_digits > int_limit_i) begin
									msgk_nxt = KSE_MK_ENTRY;
									msg_nxt  = `KSE_MSG_ENTRY;
								end else begin
									req_nxt   = 1'b1;
									state_nxt = KSE_WAIT;
								end
							end
							default: ;
						endcase
					end
					if (code_s == `KSE_KEY_POINT && !lock) begin
						scr_ch = `KSE_CH_POINT;
					end
				end else if (touch_take) begin
					touch_prev_nxt = 1'b1;
					if (!lock) begin
						moved = 1'b1;
						if (!entry_mask_i[tidx_s]) begin
							cur_on_nxt = 1'b0;
						end else if (cur_on_r && cur_pos_r == tidx_s) begin
							if (dual_mask_i[tidx_s]) begin
								cur_line_nxt = !cur_line_r;
							end else begin
								cur_on_nxt = 1'b0;
							end
						end else begin
							cur_on_nxt   = 1'b1;
							cur_pos_nxt  = tidx_s;
							cur_line_nxt = 1'b0;
						end
					end
				end
			end
			KSE_WAIT: if (verdict_valid_i) begin
				state_nxt = KSE_IDLE;
				case (verdict_i)
					KSE_V_OK: begin
						store_nxt = 1'b1;
						do_adv    = 1'b1;
						msgk_nxt  = KSE_MK_NONE;
						msg_nxt   = `KSE_MSG_NONE;
					end
					KSE_V_ADV: begin
						store_nxt = 1'b1;
						do_adv    = 1'b1;
						msgk_nxt  = KSE_MK_ADV;
						msg_nxt   = verdict_msg_i;
					end
					KSE_V_ENTRY: begin
						msgk_nxt = KSE_MK_ENTRY;
						msg_nxt  = verdict_msg_i;
					end
					default: begin
						msgk_nxt = KSE_MK_SYSOP;
						msg_nxt  = verdict_msg_i;
					end
				endcase
			end
			default: state_nxt = KSE_IDLE;
		endcase
		if (store_nxt) begin
			sfield_nxt = cur_pos_r;
			sline_nxt  = cur_line_r;
		end
		if (do_adv) begin
			moved = 1'b1;
			if (dual_mask_i[cur_pos_r] && !cur_line_r) begin
				cur_line_nxt = 1'b1;
			end else if (nx[3]) begin
				cur_pos_nxt  = nx[2:0];
				cur_line_nxt = 1'b0;
			end else begin
				cur_on_nxt = 1'b0;
			end
		end
		if (do_wipe) begin
			if (msgk_r == KSE_MK_ENTRY) begin
				scr_op   = KSE_OP_CLR;
				msgk_nxt = KSE_MK_NONE;
				msg_nxt  = `KSE_MSG_NONE;
			end else if (msgk_r == KSE_MK_SYSOP) begin
				msgk_nxt = KSE_MK_NONE;
				msg_nxt  = `KSE_MSG_NONE;
			end else if (scr_len != 4'h0) begin
				scr_op = KSE_OP_CLR;
			end else if (msgk_r == KSE_MK_ADV) begin
				msgk_nxt = KSE_MK_NONE;
				msg_nxt  = `KSE_MSG_NONE;
			end else if (cur_on_r) begin
				rest_nxt = 1'b1;
			end
		end
		if (set_sel_i) begin
			page_nxt   = set_is_wp_i ? wp_page_i : `KSE_PAGE_FIRST;
			cur_on_nxt = 1'b0;
			moved      = 1'b1;
		end
		if (moved) begin
			post_nxt = 1'b0; // Stale pairing must not rename a char after a clear
			scr_op = KSE_OP_CLR;
		end
		// Hardware sets come last so they win over a clear in the same cycle
		if (sysop_err_i) begin
			msgk_nxt = KSE_MK_SYSOP;
			msg_nxt  = sysop_msg_i;
		end
		if (warn_i) begin
			warn_nxt = 1'b1;
		end
		lock_nxt = (msgk_nxt == KSE_MK_ENTRY) || (msgk_nxt == KSE_MK_SYSOP);
		dpi_nxt  = !dp_found;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= KSE_IDLE;  msgk_r <= KSE_MK_NONE;  msg_r <= `KSE_MSG_NONE;
			key_prev_r <= 1'b0;   touch_prev_r <= 1'b0;   post_r <= 1'b0;
			cur_on_r <= 1'b0;     cur_pos_r <= 3'h0;      cur_line_r <= 1'b0;
			page_r <= `KSE_PAGE_FIRST;  warn_r <= 1'b0;   req_r <= 1'b0;
			store_r <= 1'b0;      sfield_r <= 3'h0;       sline_r <= 1'b0;
			rest_r <= 1'b0;       lock_r <= 1'b0;         dpi_r <= 1'b1;
		end else begin
			state_r <= state_nxt; msgk_r <= msgk_nxt;     msg_r <= msg_nxt;
			key_prev_r <= key_prev_nxt;  touch_prev_r <= touch_prev_nxt;
			post_r <= post_nxt;   cur_on_r <= cur_on_nxt; cur_pos_r <= cur_pos_nxt;
			cur_line_r <= cur_line_nxt;  page_r <= page_nxt;  warn_r <= warn_nxt;
			req_r <= req_nxt;     store_r <= store_nxt;   sfield_r <= sfield_nxt;
			sline_r <= sline_nxt; rest_r <= rest_nxt;     lock_r <= lock_nxt;
			dpi_r <= dpi_nxt;
		end
	end

	assign scratch_o = scr_buf;      assign scratch_len_o = scr_len;
	assign dp_implied_o = dpi_r;     assign cursor_on_o = cur_on_r;
	assign cursor_pos_o = cur_pos_r; assign cursor_line_o = cur_line_r;
	assign commit_req_o = req_r;     assign store_o = store_r;
	assign store_field_o = sfield_r; assign store_line_o = sline_r;
	assign restore_o = rest_r;       assign msg_code_o = msg_r;
	assign msg_lock_o = lock_r;      assign warn_light_o = warn_r;
	assign page_o = page_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	logic plain_key;
	assign plain_key = key_take && !lock && !set_sel_i && !touch_take;

	a_letter_pair: assert property (
		plain_key && post_r && code_s >= `KSE_KEY_POST1 && code_s <= `KSE_KEY_POST3
		|=> scr_len == $past(scr_len) && scr_buf[7:0] >= `KSE_CH_LETTER)
		else $error("letter selection changed scratch length");
	a_digit_push: assert property (
		plain_key && code_s <= `KSE_KEY_DIG_MAX && scr_len < 4'(DEPTH)
		|=> scr_len == $past(scr_len) + 4'h1 && scr_buf[7:0] == `KSE_CH_ZERO + {3'h0, $past(code_s)})
		else $error("numeral not pushed right-justified");
	a_backspace: assert property (
		plain_key && code_s == `KSE_KEY_BKSP && scr_len != 4'h0
		|=> scr_len == $past(scr_len) - 4'h1)
		else $error("backspace did not remove one character");
	a_commit_store: assert property (
		state_r == KSE_WAIT && verdict_valid_i && verdict_i == KSE_V_OK
		|=> store_o && store_field_o == $past(cur_pos_r) ##1 !store_o)
		else $error("valid commit did not store once");
	a_page_wrap: assert property (
		plain_key && code_s == `KSE_KEY_PG_FWD && page_r >= page_count_i
		|=> page_o == `KSE_PAGE_FIRST)
		else $error("forward step past last page did not wrap");
	a_ack_clear: assert property (
		plain_key && code_s == `KSE_KEY_ACK && !warn_i |=> !warn_light_o)
		else $error("acknowledge left warning light on");
	a_error_stay: assert property (
		state_r == KSE_WAIT && verdict_valid_i && verdict_i == KSE_V_ENTRY && !set_sel_i
		|=> cursor_pos_o == $past(cur_pos_r) && msg_lock_o && !store_o
		&& scr_len == $past(scr_len))
		else $error("failed commit moved cursor or lost scratch");
	a_wipe_restore: assert property (
		plain_key && code_s == `KSE_KEY_WIPE && cur_on_r && scr_len == 4'h0
		&& msgk_r == KSE_MK_NONE |=> restore_o ##1 !restore_o)
		else $error("wipe on empty scratch did not restore field");
	a_wipe_ignored: assert property (
		plain_key && code_s == `KSE_KEY_WIPE && !cur_on_r && scr_len == 4'h0
		&& msgk_r == KSE_MK_NONE && !sysop_err_i |=> !restore_o && msgk_r == KSE_MK_NONE)
		else $error("idle wipe had an effect");
	a_move_clears: assert property (
		cur_on_nxt != cur_on_r || cur_pos_nxt != cur_pos_r |=> scr_len == 4'h0)
		else $error("cursor moved without clearing scratch");
	a_lock_holds: assert property (
		lock && key_take && code_s != `KSE_KEY_WIPE && !set_sel_i
		|=> scr_len == $past(scr_len) && !commit_req_o)
		else $error("locked controls accepted a key");

	c_letter: cover property (plain_key && post_r && code_s == `KSE_KEY_POST3);
	c_commit_ok: cover property (state_r == KSE_WAIT && verdict_valid_i ##1 store_o);
	c_wrap: cover property (plain_key && code_s == `KSE_KEY_PG_FWD && page_r >= page_count_i);
	c_err_wipe: cover property (lock && key_take && code_s == `KSE_KEY_WIPE);
endmodule : kse_core

`default_nettype wire

// *** src/kse_defs.svh ***
// Constants of the keypad scratch entry block
`ifndef KSE_DEFS_SVH
`define KSE_DEFS_SVH

// ------------------------------------------------------------
// Key codes
// ------------------------------------------------------------
`define KSE_KEY_DIG_MAX   5'h09
`define KSE_KEY_POST1     5'h0a
`define KSE_KEY_POST2     5'h0b
`define KSE_KEY_POST3     5'h0c
`define KSE_KEY_BKSP      5'h0d
`define KSE_KEY_COMMIT    5'h0e
`define KSE_KEY_WIPE      5'h0f
`define KSE_KEY_ACK       5'h10
`define KSE_KEY_PG_BACK   5'h11
`define KSE_KEY_PG_FWD    5'h12
`define KSE_KEY_POINT     5'h13

// ------------------------------------------------------------
// Characters, sizes, message codes and first page number
// ------------------------------------------------------------
`define KSE_CH_BLANK      8'h20
`define KSE_CH_POINT      8'h2e
`define KSE_CH_ZERO       8'h30
`define KSE_CH_LETTER     8'h41
`define KSE_SCR_DEPTH     10
`define KSE_CHAR_W        8
`define KSE_MSG_NONE      4'h0
`define KSE_MSG_ENTRY     4'h1
`define KSE_PAGE_FIRST    4'h1

`endif

// *** src/kse_pkg.sv ***
// Types of the keypad scratch entry block
`default_nettype none

package kse_pkg;
	typedef enum logic {KSE_IDLE, KSE_WAIT} kse_state_t;
	typedef enum logic [1:0] {KSE_V_OK, KSE_V_ADV, KSE_V_ENTRY, KSE_V_SYSOP} kse_verdict_t;
	typedef enum logic [1:0] {KSE_MK_NONE, KSE_MK_ENTRY, KSE_MK_SYSOP, KSE_MK_ADV} kse_msgk_t;
	typedef enum logic [2:0] {KSE_OP_NONE, KSE_OP_PUSH, KSE_OP_REPL, KSE_OP_POP,
		KSE_OP_CLR} kse_scrop_t;
endpackage : kse_pkg

`default_nettype wire

// *** src/kse_sync.sv ***
// Two-flop synchroniser for pin inputs
`default_nettype none

module kse_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] d_i,
	output var  logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] q_r;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= d_i;
			q_r    <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule : kse_sync

`default_nettype wire

// *** src/kse_scratch.sv ***
// Right-justified scratch buffer, newest character in the low slot
`default_nettype none
`include "kse_defs.svh"

module kse_scratch
	import kse_pkg::*;
#(
	parameter int DEPTH = `KSE_SCR_DEPTH,
	parameter int W     = `KSE_CHAR_W
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire kse_scrop_t       op_i,
	input  wire logic [W-1:0]     ch_i,
	output var  logic [DEPTH*W-1:0] buf_o,
	output var  logic [3:0]       len_o
);
	localparam logic [3:0] FULL = 4'(DEPTH);

	logic [DEPTH*W-1:0] buf_r;
	logic [DEPTH*W-1:0] buf_nxt;
	logic [3:0]         len_r;
	logic [3:0]         len_nxt;

	always_comb begin
		buf_nxt = buf_r;
		len_nxt = len_r;
		case (op_i)
			KSE_OP_PUSH: if (len_r != FULL) begin
				buf_nxt = {buf_r[DEPTH*W-W-1:0], ch_i};
				len_nxt = len_r + 4'h1;
			end
			KSE_OP_REPL: buf_nxt[W-1:0] = ch_i;
			KSE_OP_POP: if (len_r != 4'h0) begin
				buf_nxt = {`KSE_CH_BLANK, buf_r[DEPTH*W-1:W]};
				len_nxt = len_r - 4'h1;
			end
			KSE_OP_CLR: begin
				buf_nxt = {DEPTH{`KSE_CH_BLANK}};
				len_nxt = 4'h0;
			end
			default: ;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_r <= {DEPTH{`KSE_CH_BLANK}};
			len_r <= 4'h0;
		end else begin
			buf_r <= buf_nxt;
			len_r <= len_nxt;
		end
	end

	assign buf_o = buf_r;
	assign len_o = len_r;
endmodule : kse_scratch

`default_nettype wire

// *** src/kse_core_note_placeholder_unused.sv ***
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// *** tb/kse_pilot.sv ***
// Pilot keypad and touch panel model
`default_nettype none

module kse_pilot (
	input  wire logic       mclk_i,
	output var  logic       key_valid_o,
	output var  logic [4:0] key_code_o,
	output var  logic       touch_valid_o,
	output var  logic [2:0] touch_idx_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		key_valid_o   = 1'b0;
		touch_valid_o = 1'b0;
		key_code_o    = 5'h1f;
		touch_idx_o   = 3'h7;
	end

	// One event per press, code steady around valid; lines scramble once released
	task automatic press(input logic t, input logic [4:0] c);
		@(posedge mclk_i) #1;
		key_code_o  = c;
		touch_idx_o = c[2:0];
		repeat (2) @(posedge mclk_i);
		#1;
		if (t) touch_valid_o = 1'b1;
		else key_valid_o = 1'b1;
		repeat (5) @(posedge mclk_i);
		#1;
		key_valid_o   = 1'b0;
		touch_valid_o = 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		key_code_o  = ~c;
		touch_idx_o = ~c[2:0];
		repeat (2) @(posedge mclk_i);
	endtask : press
endmodule : kse_pilot

`default_nettype wire

// *** tb/test_keypad_scratchpad_entry.sv ***
// Self-checking bench for the keypad scratch entry controller
`default_nettype none
`include "kse_defs.svh"

module test_keypad_scratchpad_entry import kse_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         mclk_i = 1'b0, rst_n_i = 1'b0, key_valid_i, touch_valid_i;
	logic [4:0]   key_code_i;
	logic [2:0]   touch_idx_i, cursor_pos_o, store_field_o;
	logic [7:0]   entry_mask_i = 8'h13, dual_mask_i = 8'h00;
	logic [3:0]   int_limit_i = 4'h4, page_count_i = 4'h3, wp_page_i = 4'h2;
	logic [3:0]   verdict_msg_i = 4'h1, sysop_msg_i = 4'h7;
	logic         set_sel_i = 1'b0, set_is_wp_i = 1'b0, verdict_valid_i = 1'b0;
	logic         sysop_err_i = 1'b0, warn_i = 1'b0;
	kse_verdict_t verdict_i = KSE_V_OK;
	logic [79:0]  scratch_o;
	logic [3:0]   scratch_len_o, msg_code_o, page_o;
	logic         dp_implied_o, cursor_on_o, cursor_line_o, commit_req_o, store_o;
	logic         store_line_o, restore_o, msg_lock_o, warn_light_o;
	int           errors = 0, checks = 0, n_req = 0, n_store = 0, n_rest = 0;

	always #10 mclk_i = ~mclk_i;

	// Pulses last one cycle, so they are tallied here
	always @(posedge mclk_i) begin
		if (commit_req_o === 1'b1) n_req++;
		if (store_o === 1'b1) n_store++;
		if (restore_o === 1'b1) n_rest++;
	end

	kse_pilot kse_pilot_inst (.mclk_i(mclk_i), .key_valid_o(key_valid_i),
		.key_code_o(key_code_i), .touch_valid_o(touch_valid_i), .touch_idx_o(touch_idx_i));

	kse_core kse_core_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .key_valid_i(key_valid_i),
		.key_code_i(key_code_i), .touch_valid_i(touch_valid_i), .touch_idx_i(touch_idx_i),
		.entry_mask_i(entry_mask_i), .dual_mask_i(dual_mask_i), .int_limit_i(int_limit_i),
		.page_count_i(page_count_i), .set_sel_i(set_sel_i), .set_is_wp_i(set_is_wp_i),
		.wp_page_i(wp_page_i), .verdict_valid_i(verdict_valid_i), .verdict_i(verdict_i),
		.verdict_msg_i(verdict_msg_i), .sysop_err_i(sysop_err_i), .sysop_msg_i(sysop_msg_i),
		.warn_i(warn_i), .scratch_o(scratch_o), .scratch_len_o(scratch_len_o),
		.dp_implied_o(dp_implied_o), .cursor_on_o(cursor_on_o), .cursor_pos_o(cursor_pos_o),
		.cursor_line_o(cursor_line_o), .commit_req_o(commit_req_o), .store_o(store_o),
		.store_field_o(store_field_o), .store_line_o(store_line_o), .restore_o(restore_o),
		.msg_code_o(msg_code_o), .msg_lock_o(msg_lock_o), .warn_light_o(warn_light_o),
		.page_o(page_o));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
		checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %0t %s got %h want %h", $time, m, s, e);
		end
	endtask : chk

	task automatic pk(input logic [4:0] c);
		kse_pilot_inst.press(1'b0, c);
	endtask : pk

	task automatic pt(input logic [2:0] i);
		kse_pilot_inst.press(1'b1, {2'b00, i});
	endtask : pt

	task automatic verd(input kse_verdict_t v);
		@(posedge mclk_i) #1;
		verdict_i = v;
		verdict_valid_i = 1'b1;
		@(posedge mclk_i) #1;
		verdict_valid_i = 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : verd

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_keys();
		pk(5'h01);
		pk(5'h02);
		chk(scratch_o[15:0], 16'h3132, "digits");
		chk(dp_implied_o, 1'b1, "point");
		pk(`KSE_KEY_BKSP);
		chk({scratch_len_o, scratch_o[7:0]}, 12'h131, "bksp");
		pk(5'h01);
		pk(`KSE_KEY_POST2);
		chk({scratch_len_o, scratch_o[7:0]}, 12'h245, "letter");
		pk(`KSE_KEY_WIPE);
		chk({cursor_on_o, scratch_len_o}, 5'h00, "wipe");
		pk(`KSE_KEY_WIPE);
		chk({n_rest[3:0], msg_code_o}, 8'h00, "idle wipe");
	endtask : t_keys

	task automatic t_entry();
		pt(3'h0);
		chk({cursor_on_o, cursor_pos_o}, 4'h8, "touch");
		pk(5'h05);
		pk(`KSE_KEY_COMMIT);
		chk(16'(n_req), 16'h0001, "req");
		verd(KSE_V_OK);
		chk({n_store[3:0], store_field_o}, 7'h08, "store");
		chk({cursor_pos_o, scratch_len_o}, 7'h10, "advance");
		pk(`KSE_KEY_COMMIT);
		chk({n_req[3:0], cursor_pos_o}, 7'h0c, "blank");
		pk(5'h07);
		pk(`KSE_KEY_COMMIT);
		verd(KSE_V_ENTRY);
		chk({msg_code_o, msg_lock_o, cursor_pos_o}, 8'h1c, "error");
		pk(5'h03);
		chk(scratch_len_o, 4'h1, "locked");
		pk(`KSE_KEY_WIPE);
		chk({msg_code_o, msg_lock_o, cursor_on_o, scratch_len_o}, 10'h010, "unlock");
		pk(`KSE_KEY_WIPE);
		chk(16'(n_rest), 16'h0001, "restore");
		pk(5'h02);
		pk(`KSE_KEY_COMMIT);
		verd(KSE_V_OK);
		chk({n_store[3:0], cursor_on_o}, 5'h04, "last");
		pt(3'h1);
		pt(3'h1);
		chk(cursor_on_o, 1'b0, "same point");
		pt(3'h1);
		pt(3'h2);
		chk(cursor_on_o, 1'b0, "non entry");
	endtask : t_entry

	task automatic t_dual();
		@(posedge mclk_i) #1;
		dual_mask_i = 8'h01;
		int_limit_i = 4'h2;
		verdict_msg_i = 4'h5;
		pt(3'h0);
		pt(3'h0);
		chk({cursor_on_o, cursor_pos_o, cursor_line_o}, 5'h11, "toggle");
		pt(3'h0);
		chk({cursor_on_o, cursor_pos_o, cursor_line_o}, 5'h10, "toggle back");
		pk(5'h01);
		pk(5'h02);
		pk(5'h03);
		pk(`KSE_KEY_COMMIT);
		chk({msg_code_o, msg_lock_o, scratch_len_o}, 9'h033, "format");
		chk(16'(n_req), 16'h0003, "no req");
		pk(`KSE_KEY_WIPE);
		pk(5'h01);
		pk(`KSE_KEY_POINT);
		pk(5'h05);
		chk({dp_implied_o, scratch_o[15:8]}, 9'h02e, "point");
		pk(`KSE_KEY_COMMIT);
		verd(KSE_V_ADV);
		chk({cursor_line_o, msg_code_o, msg_lock_o}, 6'h2a, "advisory");
		chk({n_store[3:0], store_line_o}, 5'h06, "adv store");
		pk(5'h07);
		pk(`KSE_KEY_COMMIT);
		verd(KSE_V_OK);
		chk({store_line_o, cursor_pos_o, cursor_line_o}, 5'h12, "line2");
	endtask : t_dual

	task automatic t_page();
		for (int i = 0; i < 3; i++) begin
			pk(`KSE_KEY_PG_FWD);
			chk(page_o, (i < 2) ? 4'(i + 2) : 4'h1, "fwd");
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk_i) #1;
			set_is_wp_i = i[0];
			set_sel_i = 1'b1;
			@(posedge mclk_i) #1;
			set_sel_i = 1'b0;
			repeat (2) @(posedge mclk_i);
			chk(page_o, i[0] ? 4'h2 : 4'h1, "set");
			pk(`KSE_KEY_PG_FWD);
		end
		for (int i = 0; i < 3; i++) begin
			pk(`KSE_KEY_PG_BACK);
			chk(page_o, (i < 2) ? 4'(2 - i) : 4'h3, "back");
		end
	endtask : t_page

	task automatic t_msg();
		@(posedge mclk_i) #1;
		warn_i = 1'b1;
		@(posedge mclk_i) #1;
		warn_i = 1'b0;
		@(posedge mclk_i) #1;
		sysop_err_i = 1'b1;
		@(posedge mclk_i) #1;
		sysop_err_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		chk({warn_light_o, msg_lock_o, msg_code_o}, 6'h37, "raise");
		// Acknowledge is locked out while the error stands, so wipe goes first
		pk(`KSE_KEY_WIPE);
		chk({msg_lock_o, msg_code_o}, 5'h00, "sysop");
		pk(`KSE_KEY_ACK);
		chk(warn_light_o, 1'b0, "ack");
	endtask : t_msg

	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	initial begin
		repeat (10) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		t_keys();
		t_entry();
		t_dual();
		t_page();
		t_msg();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge mclk_i);
		errors++;
		summarize();
	end
endmodule : test_keypad_scratchpad_entry

`default_nettype wire
